// [hw/eeprom_pkg.sv]
//==================================================================
//==================================================================
package eeprom_pkg;

   // ===============================================================
   // instruction codes
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_MEM_WR    = 8'h02;
   localparam logic [7:0] OP_STATUS_RD = 8'h05;
   localparam logic [7:0] OP_MEM_RD    = 8'h03;
   localparam logic [7:0] OP_STATUS_WR = 8'h01;

   // ===============================================================
   // sizes and counts
   localparam int ADDR_PHASE_BITS  = 16;
   localparam int MEM_ADDR_BITS    = 15;
   localparam int PAGE_BITS        = 6;
   localparam int PAGE_BYTES       = 64;
   localparam int ID_BITS          = 5;
   localparam int FIFO_DEPTH       = 8;
   localparam int WRITE_CYCLES     = 200;
   localparam logic [4:0] LAST_OP_BIT   = 5'h07;
   localparam logic [4:0] LAST_ADDR_BIT = 5'h0F;
   localparam logic [1:0] FETCH_LAT     = 2'h2;
   localparam logic [4:0] PIN_IDLE      = 5'h1F;

   // ===============================================================
   // block protect codes
   localparam logic [1:0] BP_NONE    = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF    = 2'h2;
   localparam logic [1:0] BP_FULL    = 2'h3;

   // ===============================================================
   // status register, bit 7 down to bit 0
   typedef struct packed {
      logic       protect_pin_enable;
      logic       id_page_select;
      logic       zero;
      logic       id_page_lock;
      logic [1:0] block_protect;
      logic       write_latch_flag;
      logic       busy;
   } status_t;

   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] STATUS_WR_MASK = 8'hDC;

   // one byte handed to the cell programmer
   typedef struct packed {
      logic [ADDR_PHASE_BITS-1:0] addr;
      logic [7:0]                 data;
   } prog_word_t;

   typedef enum logic [2:0] {
      ST_CMD       = 3'b000,
      ST_SET_LATCH = 3'b001,
      ST_ADDR      = 3'b010,
      ST_WDATA     = 3'b011,
      ST_RDATA     = 3'b100,
      ST_STATUS_RD = 3'b101,
      ST_STATUS_WR = 3'b110,
      ST_IGNORE    = 3'b111
   } state_t;

endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ns
// ==================================================================
// two-stage synchroniser for asynchronous pins
module pin_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // pins and synchronised levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RST_VAL;
         q        <= RST_VAL;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// [hw/byte_fifo.sv]
`timescale 1ns/1ns
// ==================================================================
// small synchronous fifo, valid/ready on both sides
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wr_ptr_reg;
   logic [PW:0]      rd_ptr_reg;
   logic             push;
   logic             pop;

   // extra pointer bit tells full from empty
   assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (PW+1)'(DEPTH);
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data  = mem[rd_ptr_reg[PW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg[PW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

// [hw/eeprom_access.sv]
`timescale 1ns/1ns
// ==================================================================
// serial eeprom command, protection and write-cycle logic
module eeprom_access
   import eeprom_pkg::*;
#(
   parameter int MEM_BITS   = eeprom_pkg::MEM_ADDR_BITS,
   parameter int WC_CYCLES  = eeprom_pkg::WRITE_CYCLES,
   parameter int FIFO_WORDS = eeprom_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // serial pins
   input  wire logic                    cs_n,
   input  wire logic                    sck,
   input  wire logic                    si,
   input  wire logic                    hold_n,
   input  wire logic                    wp_n,
   output logic                         so_out,
   output logic                         so_oe,
   // array read port, data valid one clock after address
   output logic [MEM_BITS-1:0]          rd_addr,
   input  wire logic [7:0]              rd_data,
   // cell programmer
   output logic                         prog_valid,
   input  wire logic                    prog_ready,
   output eeprom_pkg::prog_word_t       prog_word,
   // status view
   output eeprom_pkg::status_t          status_out
);
   import eeprom_pkg::*;

   // ===============================================================
   // declarations
   logic [4:0]          pins_s;
   logic                cs_s, sck_s, si_s, hold_s, wp_s;
   logic                sck_d_reg, cs_d_reg;
   logic                sck_rise, sck_fall, cs_rise, wp_block;
   state_t              state_reg;
   logic [4:0]          bit_cnt_reg;
   logic [7:0]          in_sh_reg, byte_in;
   logic [15:0]         addr_reg, addr_next;
   logic                op_wr_reg, got_data_reg;
   logic [7:0]          sr_new_reg;
   status_t             status_reg, sr_next;
   logic [7:0]          page_buf [PAGE_BYTES];
   logic [7:0]          id_page [2**ID_BITS];
   logic [PAGE_BYTES-1:0] mask_reg;
   logic [PAGE_BITS-1:0]  off_reg;
   logic                cmd_done, addr_done, byte_done, id_reject;
   logic                start_wr, start_sr, cycle_end;
   logic [PAGE_BITS:0]  walk_reg;
   logic                walk_done, id_mode_reg;
   logic [15:0]         page_reg;
   logic [MEM_BITS-1:0] wr_addr;
   logic [31:0]         wait_reg;
   logic                fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   prog_word_t          fifo_in_word, fifo_out_word;
   logic [MEM_BITS-1:0] rd_ptr_reg;
   logic [1:0]          fetch_reg;
   logic [7:0]          out_sh_reg, byte_src;

   // ===============================================================
   // functions
   function automatic logic prot_hit(input logic [1:0] bp, input logic [MEM_BITS-1:0] a);
      unique case (bp)
         BP_NONE:    prot_hit = 1'b0;
         BP_QUARTER: prot_hit = &a[MEM_BITS-1 -: 2];
         BP_HALF:    prot_hit = a[MEM_BITS-1];
         BP_FULL:    prot_hit = 1'b1;
      endcase
   endfunction

   function automatic state_t decode(input logic [7:0] b, input status_t s, input logic wpb);
      if (s.busy && b != OP_STATUS_RD) begin
         decode = ST_IGNORE;
      end else begin
         unique case (b)
            OP_SET_LATCH: decode = ST_SET_LATCH;
            OP_STATUS_RD: decode = ST_STATUS_RD;
            OP_MEM_RD:    decode = ST_ADDR;
            OP_MEM_WR:    decode = s.write_latch_flag ? ST_ADDR : ST_IGNORE;
            OP_STATUS_WR: decode = (s.write_latch_flag && !wpb) ? ST_STATUS_WR
                                                               : ST_IGNORE;
            default:      decode = ST_IGNORE;
         endcase
      end
   endfunction

   // ===============================================================
   // pin synchronisers and edge detection
   pin_sync #(.WIDTH(5), .RST_VAL(PIN_IDLE)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({cs_n, sck, si, hold_n, wp_n}),
      .q     (pins_s)
   );
   assign {cs_s, sck_s, si_s, hold_s, wp_s} = pins_s;

   // previous levels for edge finding
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_d_reg <= 1'b1;
         cs_d_reg  <= 1'b1;
      end else begin
         sck_d_reg <= sck_s;
         cs_d_reg  <= cs_s;
      end
   end

   // a paused link sees no clock edges at all
   assign sck_rise = !cs_s && hold_s && sck_s && !sck_d_reg;
   assign sck_fall = !cs_s && hold_s && !sck_s && sck_d_reg;
   assign cs_rise  = cs_s && !cs_d_reg;
   assign wp_block = status_reg.protect_pin_enable && !wp_s;
   assign byte_in  = {in_sh_reg[6:0], si_s};
   assign addr_next = {addr_reg[14:0], si_s};

   // ===============================================================
   // phase strobes
   assign cmd_done  = sck_rise && state_reg == ST_CMD && bit_cnt_reg == LAST_OP_BIT;
   assign addr_done = sck_rise && state_reg == ST_ADDR && bit_cnt_reg == LAST_ADDR_BIT;
   assign byte_done = sck_rise && bit_cnt_reg == LAST_OP_BIT;

   // id page write checks on the starting byte address
   assign id_reject = status_reg.id_page_select &&
                      (status_reg.block_protect == BP_FULL ||
                       status_reg.id_page_lock ||
                       prot_hit(status_reg.block_protect,
                                MEM_BITS'(addr_reg[ID_BITS-1:0])));
   // only a session ended on a byte boundary starts a write
   assign start_wr = cs_rise && state_reg == ST_WDATA && got_data_reg &&
                     bit_cnt_reg == '0 && !id_reject;
   assign start_sr = cs_rise && state_reg == ST_STATUS_WR && got_data_reg &&
                     bit_cnt_reg == '0;

   // ===============================================================
   // command sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_CMD;
         bit_cnt_reg  <= '0;
         in_sh_reg    <= '0;
         addr_reg     <= '0;
         op_wr_reg    <= 1'b0;
         got_data_reg <= 1'b0;
         sr_new_reg   <= '0;
      end else if (cs_s) begin
         state_reg   <= ST_CMD;
         bit_cnt_reg <= '0;
      end else if (state_reg == ST_STATUS_WR && wp_block) begin
         state_reg <= ST_IGNORE;
      end else if (sck_rise) begin
         in_sh_reg   <= byte_in;
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
         unique case (state_reg)
            ST_CMD: begin
               if (bit_cnt_reg == LAST_OP_BIT) begin
                  bit_cnt_reg  <= '0;
                  got_data_reg <= 1'b0;
                  op_wr_reg    <= byte_in == OP_MEM_WR;
                  state_reg    <= decode(byte_in, status_reg, wp_block);
               end
            end
            // any clock after the opcode spoils the latch set
            ST_SET_LATCH: state_reg <= ST_IGNORE;
            ST_ADDR: begin
               addr_reg <= addr_next;
               if (bit_cnt_reg == LAST_ADDR_BIT) begin
                  bit_cnt_reg <= '0;
                  state_reg   <= op_wr_reg ? ST_WDATA : ST_RDATA;
               end
            end
            ST_WDATA, ST_RDATA, ST_STATUS_RD: begin
               if (bit_cnt_reg == LAST_OP_BIT) begin
                  bit_cnt_reg  <= '0;
                  got_data_reg <= 1'b1;
               end
            end
            ST_STATUS_WR: begin
               if (bit_cnt_reg == LAST_OP_BIT) begin
                  bit_cnt_reg  <= '0;
                  got_data_reg <= 1'b1;
                  sr_new_reg   <= byte_in;
               end
            end
            ST_IGNORE: bit_cnt_reg <= '0;
         endcase
      end
   end

   // ===============================================================
   // page buffer loading
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= '0;
         off_reg  <= '0;
      end else if (addr_done && op_wr_reg) begin
         mask_reg <= '0;
         off_reg  <= addr_next[PAGE_BITS-1:0];
      end else if (byte_done && state_reg == ST_WDATA) begin
         mask_reg[off_reg] <= 1'b1;
         off_reg           <= off_reg + 1'b1;
      end
   end

   // wrap overwrites earlier bytes of the same page
   always_ff @(posedge clk) begin
      if (byte_done && state_reg == ST_WDATA) begin
         page_buf[off_reg] <= byte_in;
      end
   end

   // ===============================================================
   // status register
   always_comb begin
      sr_next = status_t'((status_reg & ~STATUS_WR_MASK) | (sr_new_reg & STATUS_WR_MASK));
      // setting both id bits at once leaves both alone
      if (sr_new_reg[6] && sr_new_reg[4]) begin
         sr_next.id_page_select = status_reg.id_page_select;
         sr_next.id_page_lock   = status_reg.id_page_lock;
      end
      // lock is one-way
      sr_next.id_page_lock = sr_next.id_page_lock | status_reg.id_page_lock;
      sr_next.zero         = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= status_t'(STATUS_RESET);
      end else begin
         if (cmd_done && byte_in == OP_CLR_LATCH && !status_reg.busy) begin
            status_reg.write_latch_flag <= 1'b0;
         end
         if (cs_rise && state_reg == ST_SET_LATCH) begin
            status_reg.write_latch_flag <= 1'b1;
         end
         if (cs_rise && (state_reg == ST_RDATA || state_reg == ST_WDATA)) begin
            status_reg.id_page_select <= 1'b0;
         end
         if (start_sr) begin
            status_reg <= sr_next;
            status_reg.busy <= 1'b1;
         end
         if (start_wr) begin
            status_reg.busy <= 1'b1;
         end
         if (cycle_end) begin
            status_reg.busy             <= 1'b0;
            status_reg.write_latch_flag <= 1'b0;
         end
      end
   end

   // ===============================================================
   // self-timed write cycle: walk the loaded page
   assign walk_done = walk_reg[PAGE_BITS];
   assign wr_addr   = {page_reg[MEM_BITS-1:PAGE_BITS], walk_reg[PAGE_BITS-1:0]};
   assign fifo_in_valid = status_reg.busy && !walk_done && !id_mode_reg &&
                          mask_reg[walk_reg[PAGE_BITS-1:0]] &&
                          !prot_hit(status_reg.block_protect, wr_addr);
   assign cycle_end = status_reg.busy && walk_done && !fifo_out_valid && !prog_valid &&
                      wait_reg >= 32'(WC_CYCLES - 1);

   always_comb begin
      fifo_in_word                     = '0;
      fifo_in_word.addr[MEM_BITS-1:0]  = wr_addr;
      fifo_in_word.data                = page_buf[walk_reg[PAGE_BITS-1:0]];
   end

   // protected or unloaded bytes are stepped over
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         walk_reg    <= '1;
         id_mode_reg <= 1'b0;
         page_reg    <= '0;
         wait_reg    <= '0;
      end else if (start_wr || start_sr) begin
         walk_reg    <= start_wr ? '0 : '1;
         id_mode_reg <= status_reg.id_page_select;
         page_reg    <= addr_reg;
         wait_reg    <= '0;
      end else if (status_reg.busy) begin
         wait_reg <= wait_reg + 1'b1;
         if (!walk_done && (!fifo_in_valid || fifo_in_ready)) begin
            walk_reg <= walk_reg + 1'b1;
         end
      end
   end

   // id page cells live here; address bits above the low five ignored
   always_ff @(posedge clk) begin
      if (status_reg.busy && !walk_done && id_mode_reg && mask_reg[walk_reg[PAGE_BITS-1:0]]) begin
         id_page[walk_reg[ID_BITS-1:0]] <= page_buf[walk_reg[PAGE_BITS-1:0]];
      end
   end

   byte_fifo #(.WIDTH($bits(prog_word_t)), .DEPTH(FIFO_WORDS)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_word),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_word)
   );

   // registered output stage toward the programmer
   assign fifo_out_ready = !prog_valid || prog_ready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_valid <= 1'b0;
         prog_word  <= '0;
      end else if (fifo_out_ready) begin
         prog_valid <= fifo_out_valid;
         prog_word  <= fifo_out_word;
      end
   end

   // ===============================================================
   // read path: fetch ahead, shift out on falling edges
   assign byte_src = status_reg.id_page_select ? id_page[rd_ptr_reg[ID_BITS-1:0]] : rd_data;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr_reg <= '0;
         fetch_reg  <= '0;
         out_sh_reg <= '0;
         so_out     <= 1'b0;
      end else begin
         if (addr_done && !op_wr_reg) begin
            rd_ptr_reg <= addr_next[MEM_BITS-1:0];
            fetch_reg  <= FETCH_LAT;
         end else if (byte_done && state_reg == ST_RDATA) begin
            fetch_reg <= FETCH_LAT;
         end else if (fetch_reg != '0) begin
            fetch_reg <= fetch_reg - 1'b1;
            if (fetch_reg == 2'h1) begin
               out_sh_reg <= byte_src;
               if (status_reg.id_page_select) begin
                  rd_ptr_reg[ID_BITS-1:0] <= rd_ptr_reg[ID_BITS-1:0] + 1'b1;
               end else begin
                  rd_ptr_reg <= rd_ptr_reg + 1'b1;
               end
            end
         end
         if ((cmd_done && byte_in == OP_STATUS_RD) ||
             (byte_done && state_reg == ST_STATUS_RD)) begin
            out_sh_reg <= status_reg;
         end else if (sck_fall && (state_reg == ST_RDATA || state_reg == ST_STATUS_RD)) begin
            so_out     <= out_sh_reg[7];
            out_sh_reg <= {out_sh_reg[6:0], 1'b0};
         end
      end
   end

   // output enabled only while selected, unpaused and answering
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         so_oe <= 1'b0;
      end else begin
         so_oe <= !cs_s && hold_s &&
                  (state_reg == ST_RDATA || state_reg == ST_STATUS_RD);
      end
   end

   assign rd_addr    = rd_ptr_reg;
   assign status_out = status_reg;

endmodule

// [tb/prog_array_model.sv]
`timescale 1ns/1ns
// ===========================================
// array and cell programmer: registered read, random stalls
module prog_array_model
   import eeprom_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic [14:0]            rd_addr,
   output logic      [7:0]             rd_data,
   input  wire logic                   prog_valid,
   output logic                        prog_ready,
   input  wire eeprom_pkg::prog_word_t prog_word
);
   logic [7:0] mem [0:32767];
   // blank cells hold a pattern of their address
   initial begin
      for (int i = 0; i < 32768; i++) begin
         mem[i] = i[7:0] ^ i[14:7];
      end
   end
   // stalls three clocks in four, so the fifo fills and refuses
   always @(posedge clk) begin
      rd_data <= mem[rd_addr];
      if (prog_valid && prog_ready) begin
         mem[prog_word.addr[14:0]] <= prog_word.data;
      end
      prog_ready <= ($urandom % 4) == 0;
   end
endmodule

// [tb/eeprom_access_sva.sv]
`timescale 1ns/1ns
// ===========================================
// port checker of the access logic
module eeprom_access_sva
   import eeprom_pkg::*;
#(
   parameter int MEM_BITS = 15,
   parameter int WC_CYCLES = 200,
   parameter int FIFO_WORDS = 8
) (
   input wire logic clk, rst_n, cs_n, sck, si, hold_n, wp_n,
   input wire logic so_out, so_oe, prog_valid, prog_ready,
   input wire logic [MEM_BITS-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire eeprom_pkg::prog_word_t prog_word,
   input wire eeprom_pkg::status_t status_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_pause_quiet: assert property (!hold_n [*4] |-> !so_oe)
      else $error("output driven in pause");
   chk_prog_busy: assert property (prog_valid |-> status_out.busy)
      else $error("programming while not busy");
   chk_end_unlatch: assert property ($fell(status_out.busy) |-> !status_out.write_latch_flag)
      else $error("latch kept after cycle");
   chk_start_latched: assert property ($rose(status_out.busy) |-> $past(status_out.write_latch_flag))
      else $error("cycle without latch");
   chk_start_deselect: assert property ($rose(status_out.busy) |-> cs_n && $past(cs_n, 2))
      else $error("cycle began while selected");
   chk_busy_min: assert property ($rose(status_out.busy) |=> status_out.busy [*3])
      else $error("cycle too short");
   chk_bit_five: assert property (status_out.zero == 1'b0)
      else $error("status bit five set");
   chk_full_guard: assert property (prog_valid |-> status_out.block_protect != BP_FULL)
      else $error("programming under full protect");
   cover property ($rose(status_out.busy));
   cover property (prog_valid && !prog_ready);
   cover property ($rose(so_oe));
endmodule
bind eeprom_access eeprom_access_sva #(.MEM_BITS(MEM_BITS), .WC_CYCLES(WC_CYCLES),
   .FIFO_WORDS(FIFO_WORDS)) chk (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
   .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
   .prog_valid(prog_valid), .prog_ready(prog_ready), .rd_addr(rd_addr),
   .rd_data(rd_data), .prog_word(prog_word), .status_out(status_out));

// [tb/test_spi_eeprom_access_logic.sv]
`timescale 1ns/1ns
// ===========================================
// bench: latch, status, protect, page write, reads
module test_spi_eeprom_access_logic;
   import eeprom_pkg::*;
   logic clk = 0, rst_n = 0, cs_n = 1, sck = 0, si = 0, hold_n = 1, wp_n = 1;
   logic so_out, so_oe, prog_valid, prog_ready;
   logic [14:0] rd_addr, pg;
   logic [7:0] rd_data, r;
   logic [7:0] wd [0:65];
   prog_word_t prog_word;
   status_t st;
   int bad_count = 0, total_checks = 0, off, n;
   eeprom_access #(.WC_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
      .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out),
      .so_oe(so_oe), .rd_addr(rd_addr), .rd_data(rd_data), .prog_valid(prog_valid),
      .prog_ready(prog_ready), .prog_word(prog_word), .status_out(st));
   prog_array_model FAR (.clk(clk), .rd_addr(rd_addr), .rd_data(rd_data),
      .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_word(prog_word));
   initial begin
      forever #25 clk = ~clk;
   end
   function automatic logic [7:0] fill(input logic [14:0] a);
      return a[7:0] ^ a[14:7];
   endfunction
   // last byte loaded at page offset i wins after the wrap
   function automatic logic [7:0] exp_pg(input int i);
      int k;
      k = (i - off) & 63;
      if (k < 2) k += 64;
      return wd[k];
   endfunction
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one byte each way, msb first; input read just before the rise
   task automatic xb(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         si = b[i];
         repeat (4) @(negedge clk);
         r[i] = so_out;
         sck = 1;
         repeat (4) @(negedge clk);
         sck = 0;
      end
   endtask
   task automatic sel(input logic [7:0] op);
      cs_n = 0;
      repeat (3) @(negedge clk);
      xb(op);
   endtask
   task automatic desel;
      cs_n = 1;
      repeat (6) @(negedge clk);
   endtask
   task automatic wait_ready;
      r = 8'h01;
      for (n = 0; n < 300 && r[0]; n++) begin
         sel(OP_STATUS_RD); xb(8'h00); desel;
      end
      chk8({7'h00, r[0]}, 8'h00);
   endtask
   task automatic stat_wr(input logic [7:0] v);
      sel(OP_SET_LATCH); desel;
      sel(OP_STATUS_WR); xb(v); desel; wait_ready;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #5000000;
      bad_count++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'hF0D10928));
      repeat (3) @(negedge clk);
      rst_n = 1;
      repeat (4) @(negedge clk);
      chk8(st, STATUS_RESET);
      sel(OP_MEM_WR); xb(8'h01); xb(8'h00); xb(8'h5A); desel; wait_ready;
      chk8(FAR.mem[15'h0100], fill(15'h0100));
      sel(OP_SET_LATCH); desel;
      chk8(st, 8'h02);
      sel(OP_CLR_LATCH); desel;
      chk8(st, 8'h00);
      sel(OP_SET_LATCH); xb(8'h00); desel;
      chk8(st, 8'h00);
      $display("test latch done");
      stat_wr(8'hAF);
      chk8(st, 8'h8C);
      wp_n = 0;
      stat_wr(8'h00);
      chk8(st, 8'h8E);
      wp_n = 1;
      sel(OP_STATUS_WR);
      fork
         xb(8'h00);
         begin repeat (20) @(negedge clk); wp_n = 0; end
      join
      desel;
      chk8(st, 8'h8E);
      wp_n = 1;
      stat_wr(8'h08);
      chk8(st, 8'h08);
      stat_wr(8'h08);
      sel(OP_SET_LATCH); desel;
      sel(OP_MEM_WR); xb(8'hC0); xb(8'h00); xb(8'h11); desel; wait_ready;
      chk8(FAR.mem[15'h4000], fill(15'h4000));
      stat_wr(8'h00);
      $display("test protect done");
      pg = 15'($urandom_range(64, 32640)) & 15'h7FC0;
      off = $urandom_range(0, 63);
      sel(OP_SET_LATCH); desel;
      sel(OP_MEM_WR); xb({1'b1, pg[14:8]}); xb(pg[7:0] | 8'(off));
      for (int i = 0; i < 66; i++) begin
         wd[i] = 8'($urandom);
         xb(wd[i]);
      end
      desel; wait_ready;
      chk8(st, 8'h00);
      sel(OP_MEM_RD); xb({1'b0, pg[14:8]}); xb(pg[7:0]);
      for (int i = 0; i < 64; i++) begin
         xb(8'h00);
         chk8(r, exp_pg(i));
      end
      desel;
      sel(OP_MEM_RD); xb(8'hFF); xb(8'hFF); xb(8'h00);
      chk8(r, fill(15'h7FFF));
      xb(8'h00);
      chk8(r, fill(15'h0000));
      // let the last falling clock edge reach the design before pausing
      repeat (4) @(negedge clk);
      hold_n = 0;
      repeat (6) @(negedge clk);
      chk8({7'h00, so_oe}, 8'h00);
      hold_n = 1;
      repeat (3) @(negedge clk);
      chk8({7'h00, so_oe}, 8'h01);
      xb(8'h00); desel;
      chk8(r, fill(15'h0001));
      $display("test page done");
      // id page byte three: top address bits are ignored
      stat_wr(8'h40);
      sel(OP_SET_LATCH); desel;
      sel(OP_MEM_WR); xb(8'hFF); xb(8'hE3); xb(8'hA5); desel; wait_ready;
      chk8(st, 8'h00);
      chk8(FAR.mem[15'h7FE3], fill(15'h7FE3));
      stat_wr(8'h40);
      sel(OP_MEM_RD); xb(8'h00); xb(8'h03); xb(8'h00); desel;
      chk8(r, 8'hA5);
      chk8(st, 8'h00);
      // lock is one-way, so this case runs last
      stat_wr(8'h10);
      stat_wr(8'h40);
      sel(OP_SET_LATCH); desel;
      sel(OP_MEM_WR); xb(8'h00); xb(8'h03); xb(8'h3C); desel;
      chk8(st, 8'h12);
      $display("test id page done");
      end_of_test;
   end
endmodule
